// [logic/lpsc_pkg.sv]
// package for the low-power stop/halt controller
package lpsc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int MAX_PERIPH = 24;
	// register byte offsets
	localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] PDN_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;
	// control register fields
	localparam int CTRL_WDT_OSC_BIT = 0;
	localparam int CTRL_WDT_BIT = 1;
	localparam int CTRL_AMP_BIT = 2;
	localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0003;
	localparam logic [DATA_W-1:0] CTRL_MASK = 32'h0000_0007;
	// power control register fields
	localparam int PDN_WDT_BIT = 0;
	localparam int PDN_BOD_BIT = 1;
	localparam int PDN_AMP_BIT = 2;
	localparam int PDN_PERIPH_LSB = 8;
	localparam logic [DATA_W-1:0] PDN_RST = 32'h0000_0000;
	// status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_OSC_OK_BIT = 4;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// oscillator settle time after its ready pin rises
	localparam int CLK_PERIOD_NS = 100;
	localparam int OSC_SETTLE_NS = 2000;
	localparam int OSC_SETTLE_CYC =
		(OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W = 8;
	localparam logic [SETTLE_W-1:0] SETTLE_LAST =
		SETTLE_W'(OSC_SETTLE_CYC - 1);

	typedef enum logic [1:0] {
		MODE_ACTIVE,
		MODE_HALT,
		MODE_STOP,
		MODE_WAKE
	} lpsc_mode_type;

	typedef struct packed {
		logic osc_en;
		logic xtal_pins_en;
		logic sys_clk_en;
		logic cpu_run;
		logic ip_advance;
		logic wdt_osc_en;
		logic wdt_run;
		logic bod_en;
		logic amp_en;
	} lpsc_gate_type;
endpackage : lpsc_pkg

// [logic/lpsc_ctrl.sv]
// low-power stop/halt controller with an AXI4-Lite register slave
// Overview of operation
// - stop instruction enters STOP mode
// - HALT stops only the CPU and pointer
// - STOP powers down all but four blocks
// - STOP halts the main oscillator and crystal pins
// - STOP halts system clock, CPU, pointer
// - watchdog RC oscillator runs if enabled
// - watchdog logic runs in STOP if enabled
// - brown-out runs in STOP per option bit
// - amplifier runs in STOP if enabled
// - other peripherals idle during STOP
// - power-down bit overrides block enables
// - STOP left only by recovery
`timescale 1ns/1ns
`default_nettype none
module lpsc_ctrl #(
	parameter int NPER = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [lpsc_pkg::ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [lpsc_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [lpsc_pkg::ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [lpsc_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	input wire logic stop_req,
	input wire logic halt_req,
	input wire logic wake_irq,
	input wire logic recovery_pin,
	input wire logic osc_ready_pin,
	input wire logic bod_stop_option,
	input wire logic [NPER-1:0] periph_en_req,
	output lpsc_pkg::lpsc_gate_type gate,
	output logic [NPER-1:0] periph_en
);
	if (NPER < 1 || NPER > lpsc_pkg::MAX_PERIPH) begin : g_nper_check
		$error("NPER out of range");
	end

	lpsc_pkg::lpsc_mode_type mode_reg, mode_next;
	logic [lpsc_pkg::DATA_W-1:0] ctrl_reg, pdn_reg;
	logic [1:0] rec_sync_reg, osc_sync_reg, bod_sync_reg;
	logic rec_s, osc_ok_s, bod_opt_s;
	logic [lpsc_pkg::SETTLE_W-1:0] settle_reg;
	logic [NPER-1:0] pdn_periph;
	logic aw_got_reg, w_got_reg;
	logic [lpsc_pkg::ADDR_W-1:0] waddr_reg;
	logic [lpsc_pkg::DATA_W-1:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_take, w_take, ar_take, do_write, bvalid_next;

	// pin synchronisers, first stage read only by the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec_sync_reg <= 2'h0;
			osc_sync_reg <= 2'h0;
			bod_sync_reg <= 2'h0;
		end else begin
			rec_sync_reg <= {rec_sync_reg[0], recovery_pin};
			osc_sync_reg <= {osc_sync_reg[0], osc_ready_pin};
			bod_sync_reg <= {bod_sync_reg[0], bod_stop_option};
		end
	end
	assign rec_s = rec_sync_reg[1];
	assign osc_ok_s = osc_sync_reg[1];
	assign bod_opt_s = bod_sync_reg[1];
	assign pdn_periph = pdn_reg[lpsc_pkg::PDN_PERIPH_LSB +: NPER];

	// mode sequencing
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			lpsc_pkg::MODE_ACTIVE: begin
				if (stop_req)
					mode_next = lpsc_pkg::MODE_STOP;
				else if (halt_req)
					mode_next = lpsc_pkg::MODE_HALT;
			end
			lpsc_pkg::MODE_HALT: begin
				if (wake_irq || rec_s)
					mode_next = lpsc_pkg::MODE_ACTIVE;
			end
			lpsc_pkg::MODE_STOP: begin
				if (rec_s)
					mode_next = lpsc_pkg::MODE_WAKE;
			end
			lpsc_pkg::MODE_WAKE: begin
				if (osc_ok_s && settle_reg == lpsc_pkg::SETTLE_LAST)
					mode_next = lpsc_pkg::MODE_ACTIVE;
			end
			default: mode_next = lpsc_pkg::MODE_ACTIVE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_reg <= lpsc_pkg::MODE_ACTIVE;
		else
			mode_reg <= mode_next;
	end

	// oscillator settle count while waking
	always_ff @(posedge aclk) begin
		if (!aresetn)
			settle_reg <= '0;
		else if (mode_reg == lpsc_pkg::MODE_WAKE && osc_ok_s)
			settle_reg <= settle_reg + 1'b1;
		else
			settle_reg <= '0;
	end

	// block gating from the current mode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate <= '0;
			periph_en <= '0;
		end else begin
			gate.osc_en <= mode_reg != lpsc_pkg::MODE_STOP;
			gate.xtal_pins_en <= mode_reg != lpsc_pkg::MODE_STOP;
			gate.sys_clk_en <= mode_reg == lpsc_pkg::MODE_ACTIVE ||
				mode_reg == lpsc_pkg::MODE_HALT;
			gate.cpu_run <= mode_reg == lpsc_pkg::MODE_ACTIVE;
			gate.ip_advance <= mode_reg == lpsc_pkg::MODE_ACTIVE;
			gate.wdt_osc_en <= ctrl_reg[lpsc_pkg::CTRL_WDT_OSC_BIT] &
				~pdn_reg[lpsc_pkg::PDN_WDT_BIT];
			gate.wdt_run <= ctrl_reg[lpsc_pkg::CTRL_WDT_BIT] &
				~pdn_reg[lpsc_pkg::PDN_WDT_BIT];
			gate.bod_en <= ~pdn_reg[lpsc_pkg::PDN_BOD_BIT] &
				(mode_reg != lpsc_pkg::MODE_STOP || bod_opt_s);
			gate.amp_en <= ctrl_reg[lpsc_pkg::CTRL_AMP_BIT] &
				~pdn_reg[lpsc_pkg::PDN_AMP_BIT];
			if (mode_reg == lpsc_pkg::MODE_STOP ||
				mode_reg == lpsc_pkg::MODE_WAKE)
				periph_en <= '0;
			else
				periph_en <= periph_en_req & ~pdn_periph;
		end
	end

	// write channel handshakes
	assign aw_take = awvalid & awready;
	assign w_take = wvalid & wready;
	assign do_write = aw_got_reg & w_got_reg & ~bvalid;
	assign bvalid_next = do_write | (bvalid & ~bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= 4'h0;
		end else begin
			if (aw_take)
				waddr_reg <= awaddr;
			if (w_take) begin
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end
			aw_got_reg <= (aw_got_reg | aw_take) & ~do_write;
			w_got_reg <= (w_got_reg | w_take) & ~do_write;
			awready <= ~((aw_got_reg | aw_take) & ~do_write) & ~bvalid_next;
			wready <= ~((w_got_reg | w_take) & ~do_write) & ~bvalid_next;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= lpsc_pkg::RESP_OKAY;
		end else begin
			bvalid <= bvalid_next;
			if (do_write)
				bresp <= (waddr_reg == lpsc_pkg::CTRL_OFS ||
					waddr_reg == lpsc_pkg::PDN_OFS ||
					waddr_reg == lpsc_pkg::STAT_OFS) ?
					lpsc_pkg::RESP_OKAY : lpsc_pkg::RESP_SLVERR;
		end
	end

	// register file updates with byte strobes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= lpsc_pkg::CTRL_RST;
			pdn_reg <= lpsc_pkg::PDN_RST;
		end else if (do_write) begin
			for (int b = 0; b < 4; b++) begin
				if (wstrb_reg[b] && waddr_reg == lpsc_pkg::CTRL_OFS)
					ctrl_reg[8*b +: 8] <= wdata_reg[8*b +: 8] &
						lpsc_pkg::CTRL_MASK[8*b +: 8];
				if (wstrb_reg[b] && waddr_reg == lpsc_pkg::PDN_OFS)
					pdn_reg[8*b +: 8] <= wdata_reg[8*b +: 8];
			end
		end
	end

	// read channel
	assign ar_take = arvalid & arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= lpsc_pkg::RESP_OKAY;
		end else begin
			arready <= ~ar_take & ~(rvalid & ~rready);
			if (ar_take) begin
				rvalid <= 1'b1;
				rresp <= lpsc_pkg::RESP_OKAY;
				case (araddr)
					lpsc_pkg::CTRL_OFS: rdata <= ctrl_reg;
					lpsc_pkg::PDN_OFS: rdata <= pdn_reg;
					lpsc_pkg::STAT_OFS: begin
						rdata <= '0;
						rdata[lpsc_pkg::STAT_MODE_LSB +: 2] <= mode_reg;
						rdata[lpsc_pkg::STAT_OSC_OK_BIT] <= osc_ok_s;
					end
					default: begin
						rdata <= '0;
						rresp <= lpsc_pkg::RESP_SLVERR;
					end
				endcase
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_stop_cmd;
		mode_reg == lpsc_pkg::MODE_ACTIVE && stop_req;
	endsequence
	sequence s_in_stop;
		mode_reg == lpsc_pkg::MODE_STOP;
	endsequence

	chk_stop_entry: assert property (s_stop_cmd |=> s_in_stop ##1
		!gate.cpu_run && !gate.sys_clk_en)
		else $error("stop request did not stop the core");
	chk_halt_gating: assert property (
		mode_reg == lpsc_pkg::MODE_HALT |=> !gate.cpu_run && gate.sys_clk_en)
		else $error("halt gating wrong");
	chk_stop_periph: assert property (s_in_stop |=> periph_en == '0)
		else $error("peripheral enabled in stop");
	chk_osc_stopped: assert property (s_in_stop |=>
		!gate.osc_en && !gate.xtal_pins_en)
		else $error("oscillator running in stop");
	chk_cpu_frozen: assert property (s_in_stop |=>
		!gate.sys_clk_en && !gate.ip_advance)
		else $error("clock or pointer running in stop");
	chk_wdt_osc_kept: assert property (s_in_stop |=>
		gate.wdt_osc_en == ($past(ctrl_reg[lpsc_pkg::CTRL_WDT_OSC_BIT]) &
		~$past(pdn_reg[lpsc_pkg::PDN_WDT_BIT])))
		else $error("watchdog oscillator gating wrong");
	chk_wdt_run_kept: assert property (s_in_stop |=>
		gate.wdt_run == ($past(ctrl_reg[lpsc_pkg::CTRL_WDT_BIT]) &
		~$past(pdn_reg[lpsc_pkg::PDN_WDT_BIT])))
		else $error("watchdog logic gating wrong");
	chk_bod_option: assert property (s_in_stop |=>
		gate.bod_en == ($past(bod_opt_s) &
		~$past(pdn_reg[lpsc_pkg::PDN_BOD_BIT])))
		else $error("brown-out gating wrong");
	chk_amp_kept: assert property (s_in_stop |=>
		gate.amp_en == ($past(ctrl_reg[lpsc_pkg::CTRL_AMP_BIT]) &
		~$past(pdn_reg[lpsc_pkg::PDN_AMP_BIT])))
		else $error("amplifier gating wrong");
	chk_others_idle: assert property (
		s_in_stop [*2] |-> periph_en == '0 && !gate.cpu_run)
		else $error("block active during stop");
	chk_pdn_override: assert property (
		1'b1 |=> (periph_en & $past(pdn_periph)) == '0 &&
		!(gate.amp_en && $past(pdn_reg[lpsc_pkg::PDN_AMP_BIT])))
		else $error("power-down bit did not override");
	chk_stop_exit: assert property (
		mode_reg == lpsc_pkg::MODE_STOP && !rec_s |=> s_in_stop)
		else $error("stop left without recovery");
	chk_wake_stable: assert property (
		mode_reg == lpsc_pkg::MODE_ACTIVE &&
		$past(mode_reg) == lpsc_pkg::MODE_WAKE |->
		$past(osc_ok_s) && $past(settle_reg) == lpsc_pkg::SETTLE_LAST)
		else $error("clock released before oscillator settled");
	chk_wake_gated: assert property (
		mode_reg == lpsc_pkg::MODE_WAKE |=> !gate.sys_clk_en && gate.osc_en)
		else $error("clock released during wake");
endmodule : lpsc_ctrl
`default_nettype wire

// [dv/lpsc_osc_model.sv]
// oscillator model answering the controller's enable
`timescale 1ns/1ns
`default_nettype none
module lpsc_osc_model (
	input wire logic aclk,
	input wire logic osc_en,
	input wire logic [3:0] dly,
	output logic osc_ready_pin
);
	int cnt = 0;
	initial osc_ready_pin = 1'b0;
	// ready only after a start-up delay, dropped at once when stopped
	always @(posedge aclk) begin
		cnt <= osc_en ? cnt + 1 : 0;
		osc_ready_pin <= osc_en && (cnt > int'(dly));
	end
endmodule : lpsc_osc_model
`default_nettype wire

// [dv/low_power_stop_halt_control_test.sv]
// self-checking bench for the stop/halt controller
`timescale 1ns/1ns
`default_nettype none
module low_power_stop_halt_control_test;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [3:0] awaddr, araddr, wstrb, dly;
	logic [31:0] wdata, rdata, ctrl, pdn, rd;
	logic awready, wready, bvalid, arready, rvalid, opt;
	logic [1:0] bresp, rresp, rs;
	logic stop_req, halt_req, wake_irq, recovery_pin, osc_ready_pin;
	logic [7:0] preq, periph_en;
	lpsc_pkg::lpsc_gate_type gate;
	int n_mismatch = 0;
	int check_count = 0;
	int seed = 32'ha443;
	int k;
	lpsc_ctrl #(.NPER(8)) uut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.stop_req(stop_req), .halt_req(halt_req), .wake_irq(wake_irq),
		.recovery_pin(recovery_pin), .osc_ready_pin(osc_ready_pin),
		.bod_stop_option(opt), .periph_en_req(preq), .gate(gate),
		.periph_en(periph_en));
	lpsc_osc_model osc (.aclk(aclk), .osc_en(gate.osc_en), .dly(dly),
		.osc_ready_pin(osc_ready_pin));
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [3:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rdr
	function automatic logic [8:0] exp_gate(input logic [1:0] m);
		return {m != 2, m != 2, m != 2, m == 0, m == 0, ctrl[0] & ~pdn[0],
			ctrl[1] & ~pdn[0], ~pdn[1] & (m != 2 | opt), ctrl[2] & ~pdn[2]};
	endfunction : exp_gate
	task automatic gchk(input logic [1:0] m);
		logic [8:0] g;
		g = gate;
		chk(32'(g), 32'(exp_gate(m)), "gate");
		chk(32'(periph_en), 32'(preq & ~pdn[15:8] & {8{m != 2}}), "periph");
		rdr(lpsc_pkg::STAT_OFS);
		chk(32'(rd[1:0]), 32'(m), "mode");
	endtask : gchk
	task automatic pulse(input logic s);
		@(posedge aclk);
		if (s) stop_req <= 1'b1;
		else halt_req <= 1'b1;
		@(posedge aclk);
		stop_req <= 1'b0;
		halt_req <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask : pulse
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, stop_req} = 6'h00;
		{halt_req, wake_irq, recovery_pin, opt, aresetn} = 5'h00;
		{awaddr, araddr, wstrb, dly, wdata, preq} = 56'h0;
		ctrl = 32'h3;
		pdn = 32'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		gchk(0);
		rdr(lpsc_pkg::CTRL_OFS);
		chk(rd, lpsc_pkg::CTRL_RST, "ctrl reset");
		rdr(4'hc);
		chk(rd, 32'h0, "unmapped data");
		chk(32'(rs), 32'(lpsc_pkg::RESP_SLVERR), "unmapped read");
		wr(4'hc, 32'h1);
		chk(32'(rs), 32'(lpsc_pkg::RESP_SLVERR), "unmapped write");
		wr(lpsc_pkg::STAT_OFS, 32'hffff_ffff);
		chk(32'(rs), 32'(lpsc_pkg::RESP_OKAY), "stat write");
		wr(lpsc_pkg::PDN_OFS, 32'hffff_ffff, 4'h2);
		rdr(lpsc_pkg::PDN_OFS);
		chk(rd, 32'h0000_ff00, "byte strobe");
		wr(lpsc_pkg::CTRL_OFS, 32'hffff_fff8);
		rdr(lpsc_pkg::CTRL_OFS);
		chk(rd, 32'h0, "ctrl mask");
		for (int i = 0; i < 6; i++) begin
			ctrl = (i == 0) ? 32'h7 : 32'($random(seed)) & 32'h7;
			pdn = (i == 1) ? 32'hff07 : 32'($random(seed)) & 32'hff07;
			opt <= 1'($random(seed));
			preq <= 8'($random(seed));
			dly <= (i == 2) ? 4'hf : 4'($random(seed));
			wr(lpsc_pkg::CTRL_OFS, ctrl);
			wr(lpsc_pkg::PDN_OFS, pdn);
			rdr(lpsc_pkg::PDN_OFS);
			chk(rd, pdn, "pdn readback");
			gchk(0);
			pulse(0);
			gchk(1);
			pulse(1);
			gchk(1);
			wake_irq <= 1'b1;
			repeat (3) @(posedge aclk);
			wake_irq <= 1'b0;
			gchk(0);
			wake_irq <= 1'b1;
			pulse(1);
			gchk(2);
			wake_irq <= 1'b0;
			gchk(2);
			recovery_pin <= 1'b1;
			k = 0;
			do begin
				@(posedge aclk);
				k++;
			end while (gate.sys_clk_en !== 1'b1 && k < 200);
			recovery_pin <= 1'b0;
			chk(32'(k > lpsc_pkg::OSC_SETTLE_CYC && k < 200), 32'h1,
				"settle");
			repeat (2) @(posedge aclk);
			gchk(0);
			$display("test %0d done", i);
		end
		tally_and_finish();
	end
	initial begin
		#(100 * 30000);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : low_power_stop_halt_control_test
`default_nettype wire
